// ===== core/tmr_presc_cfg.svh
`ifndef TMR_PRESC_CFG_SVH
`define TMR_PRESC_CFG_SVH

// register byte offsets
`define OFS_SYNC_CTRL 12'h000
`define OFS_CLK_SEL 12'h004
`define OFS_DIV_COUNT 12'h008

// timer_sync_control field positions
`define BIT_HOLD 7
`define BIT_ASYNC_RST 1
`define BIT_SYNC_RST 0

// clock select field positions
`define SEL0_LSB 0
`define SEL1_LSB 4
`define SEL_W 3

// divider size and tap masks
`define DIV_WIDTH 10
`define TAP8_BITS 3
`define TAP64_BITS 6
`define TAP256_BITS 8
`define TAP1024_BITS 10

// reset values
`define CTRL_RESET 3'h0
`define SEL_RESET 3'h0

`endif

// ===== core/tmr_presc_pkg.sv
package tmr_presc_pkg;

  typedef enum logic [2:0] {
    SEL_STOP = 3'h0,
    SEL_DIRECT = 3'h1,
    SEL_DIV8 = 3'h2,
    SEL_DIV64 = 3'h3,
    SEL_DIV256 = 3'h4,
    SEL_DIV1024 = 3'h5,
    SEL_EXT_FALL = 3'h6,
    SEL_EXT_RISE = 3'h7
  } clk_sel_t;

  typedef struct packed {
    logic hold;
    logic async_rst;
    logic sync_rst;
  } sync_ctrl_t;

  typedef enum logic [1:0] {
    REG_CTRL,
    REG_SEL,
    REG_COUNT,
    REG_NONE
  } reg_id_t;

endpackage

// ===== core/shared_timer_prescaler.sv
`timescale 1ns/100ps
`include "tmr_presc_cfg.svh"

module shared_timer_prescaler #(
  parameter int DIV_W = `DIV_WIDTH,
  parameter int NUM_TIMERS = 2
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic PREADY,
  output logic [31:0] PRDATA,
  output logic PSLVERR,
  // external count pins
  input wire logic [NUM_TIMERS-1:0] EXT_COUNT_PIN,
  // timer ticks and reset level for the separate timer
  output logic [NUM_TIMERS-1:0] TIMER_TICK,
  output logic ASYNC_PRESCALER_RESET
);

  logic pready_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic [DIV_W-1:0] div_q;
  tmr_presc_pkg::sync_ctrl_t ctrl_q;
  logic [NUM_TIMERS-1:0][2:0] sel_q;
  logic [NUM_TIMERS-1:0] tick_q;
  logic [3:0] tap;
  logic presc_run;
  logic access;
  logic wr_fire;
  logic wr_ctrl;
  logic wr_sel;
  tmr_presc_pkg::reg_id_t rd_id;

  function automatic tmr_presc_pkg::reg_id_t reg_of(input logic [11:0] a);
    case (a)
      `OFS_SYNC_CTRL: reg_of = tmr_presc_pkg::REG_CTRL;
      `OFS_CLK_SEL: reg_of = tmr_presc_pkg::REG_SEL;
      `OFS_DIV_COUNT: reg_of = tmr_presc_pkg::REG_COUNT;
      default: reg_of = tmr_presc_pkg::REG_NONE;
    endcase
  endfunction

  function automatic logic tick_of(input logic [2:0] sel,
                                   input logic [3:0] taps,
                                   input logic run,
                                   input logic rise,
                                   input logic fall);
    case (tmr_presc_pkg::clk_sel_t'(sel))
      tmr_presc_pkg::SEL_STOP: tick_of = 1'b0;
      tmr_presc_pkg::SEL_DIRECT: tick_of = 1'b1;
      tmr_presc_pkg::SEL_DIV8: tick_of = taps[0] & run;
      tmr_presc_pkg::SEL_DIV64: tick_of = taps[1] & run;
      tmr_presc_pkg::SEL_DIV256: tick_of = taps[2] & run;
      tmr_presc_pkg::SEL_DIV1024: tick_of = taps[3] & run;
      tmr_presc_pkg::SEL_EXT_FALL: tick_of = fall;
      tmr_presc_pkg::SEL_EXT_RISE: tick_of = rise;
      default: tick_of = 1'b0;
    endcase
  endfunction

  // apb: one wait state so that all outputs stay registered
  assign access = PSEL & PENABLE;
  assign wr_fire = access & pready_q & PWRITE;
  assign rd_id = reg_of(PADDR);
  assign wr_ctrl = wr_fire & (rd_id == tmr_presc_pkg::REG_CTRL);
  assign wr_sel = wr_fire & (rd_id == tmr_presc_pkg::REG_SEL);

  always_ff @(posedge CLK) begin
    if (RESET) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= access & ~pready_q;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (access & ~pready_q) begin
      pslverr_q <= (rd_id == tmr_presc_pkg::REG_NONE);
      case (rd_id)
        tmr_presc_pkg::REG_CTRL: begin
          prdata_q <= 32'h0000_0000;
          prdata_q[`BIT_HOLD] <= ctrl_q.hold;
          prdata_q[`BIT_ASYNC_RST] <= ctrl_q.async_rst;
          prdata_q[`BIT_SYNC_RST] <= ctrl_q.sync_rst;
        end
        tmr_presc_pkg::REG_SEL: begin
          prdata_q <= 32'h0000_0000;
          prdata_q[`SEL0_LSB +: `SEL_W] <= sel_q[0];
          prdata_q[`SEL1_LSB +: `SEL_W] <= sel_q[1];
        end
        tmr_presc_pkg::REG_COUNT: begin
          prdata_q <= 32'(div_q);
        end
        default: begin
          prdata_q <= 32'h0000_0000;
        end
      endcase
    end else begin
      pslverr_q <= 1'b0;
    end
  end

  // sync control: written reset bits persist only under hold
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ctrl_q <= `CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q.hold <= PWDATA[`BIT_HOLD];
      ctrl_q.async_rst <= PWDATA[`BIT_ASYNC_RST];
      ctrl_q.sync_rst <= PWDATA[`BIT_SYNC_RST];
    end else if (!ctrl_q.hold) begin
      ctrl_q.async_rst <= 1'b0;
      ctrl_q.sync_rst <= 1'b0;
    end
  end

  // each timer keeps its own select field
  always_ff @(posedge CLK) begin
    if (RESET) begin
      sel_q[0] <= `SEL_RESET;
      sel_q[1] <= `SEL_RESET;
    end else if (wr_sel) begin
      sel_q[0] <= PWDATA[`SEL0_LSB +: `SEL_W];
      sel_q[1] <= PWDATA[`SEL1_LSB +: `SEL_W];
    end
  end

  // one free-running divider serves both timers
  always_ff @(posedge CLK) begin
    if (RESET || ctrl_q.sync_rst) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  // taps fire for one cycle per period; phase is not tied to start
  assign tap[0] = &div_q[`TAP8_BITS-1:0];
  assign tap[1] = &div_q[`TAP64_BITS-1:0];
  assign tap[2] = &div_q[`TAP256_BITS-1:0];
  assign tap[3] = &div_q[`TAP1024_BITS-1:0];
  // held prescaler reset halts prescaled timers
  assign presc_run = ~ctrl_q.sync_rst;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      ASYNC_PRESCALER_RESET <= 1'b0;
    end else begin
      ASYNC_PRESCALER_RESET <= ctrl_q.async_rst;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_TIMERS; gi++) begin : g_tmr
      logic pin_lat;
      logic sync1_q;
      logic sync2_q;
      logic prev_q;
      logic rise;
      logic fall;

      // latch open while clock high, so the pin is caught half a cycle on
      always_latch begin
        if (CLK) begin
          pin_lat = EXT_COUNT_PIN[gi];
        end
      end

      always_ff @(posedge CLK) begin
        if (RESET) begin
          sync1_q <= 1'b0;
          sync2_q <= 1'b0;
          prev_q <= 1'b0;
        end else begin
          sync1_q <= pin_lat;
          sync2_q <= sync1_q;
          prev_q <= sync2_q;
        end
      end

      assign rise = sync2_q & ~prev_q;
      assign fall = ~sync2_q & prev_q;

      // pin ticks bypass the divider and its reset
      always_ff @(posedge CLK) begin
        if (RESET) begin
          tick_q[gi] <= 1'b0;
        end else begin
          tick_q[gi] <= tick_of(sel_q[gi], tap, presc_run, rise, fall);
        end
      end

      direct_tick_a: assert property (@(posedge CLK) disable iff (RESET)
        sel_q[gi] == 3'h1 |=> tick_q[gi])
        else $error("direct select missed a tick");

      div8_tap_a: assert property (@(posedge CLK) disable iff (RESET)
        tick_q[gi] && $past(sel_q[gi]) == 3'h2
        |-> $past(div_q[2:0]) == 3'h7 && !$past(ctrl_q.sync_rst))
        else $error("divide by 8 tick off its tap");

      first_tick_a: assert property (@(posedge CLK) disable iff (RESET)
        $rose(sel_q[gi] == 3'h2) && !ctrl_q.sync_rst
        |-> ##[1:9] (tick_q[gi] || sel_q[gi] != 3'h2 || ctrl_q.sync_rst))
        else $error("first prescaled tick later than N+1");

      rise_tick_a: assert property (@(posedge CLK) disable iff (RESET)
        sel_q[gi] == 3'h7
        |=> tick_q[gi] == $past(sync2_q && !prev_q))
        else $error("rising edge tick mismatch");

      fall_tick_a: assert property (@(posedge CLK) disable iff (RESET)
        sel_q[gi] == 3'h6
        |=> tick_q[gi] == $past(!sync2_q && prev_q))
        else $error("falling edge tick mismatch");

      fall_ignored_a: assert property (@(posedge CLK) disable iff (RESET)
        sel_q[gi] == 3'h6 && fall && ctrl_q.sync_rst |=> tick_q[gi])
        else $error("pin tick blocked by prescaler reset");

      // pin may move in either clock phase, hence the one-cycle spread
      pin_latency_a: assert property (@(posedge CLK) disable iff (RESET)
        sel_q[gi] == 3'h7 && $rose(EXT_COUNT_PIN[gi])
        ##1 (sel_q[gi] == 3'h7 && EXT_COUNT_PIN[gi])
        |-> ##[2:3] tick_q[gi])
        else $error("pin edge not ticked within latency");

      stop_quiet_a: assert property (@(posedge CLK) disable iff (RESET)
        sel_q[gi] == 3'h0 |=> !tick_q[gi])
        else $error("stopped timer ticked");

      tap1024_a: assert property (@(posedge CLK) disable iff (RESET)
        tick_q[gi] && $past(sel_q[gi]) == 3'h5 |-> $past(div_q) == '1)
        else $error("divide by 1024 tick off its tap");

      div64_tap_a: assert property (@(posedge CLK) disable iff (RESET)
        tick_q[gi] && $past(sel_q[gi]) == 3'h3
        |-> $past(div_q[5:0]) == 6'h3F)
        else $error("divide by 64 tick off its tap");

      div256_tap_a: assert property (@(posedge CLK) disable iff (RESET)
        tick_q[gi] && $past(sel_q[gi]) == 3'h4
        |-> $past(div_q[7:0]) == 8'hFF)
        else $error("divide by 256 tick off its tap");

      // only the prescaled selects halt; direct and pin ticks go on
      held_stop_a: assert property (@(posedge CLK) disable iff (RESET)
        ctrl_q.sync_rst && sel_q[gi] >= 3'h2 && sel_q[gi] <= 3'h5
        |=> !tick_q[gi])
        else $error("prescaled tick while prescaler held");
    end
  endgenerate

  assign PREADY = pready_q;
  assign PRDATA = prdata_q;
  assign PSLVERR = pslverr_q;
  assign TIMER_TICK = tick_q;

  free_run_a: assert property (@(posedge CLK) disable iff (RESET)
    !$past(RESET) && !$past(ctrl_q.sync_rst)
    |-> div_q == DIV_W'($past(div_q) + 1'b1))
    else $error("divider did not advance");

  sel_split_a: assert property (@(posedge CLK) disable iff (RESET)
    wr_sel |=> sel_q[0] == $past(PWDATA[2:0])
      && sel_q[1] == $past(PWDATA[6:4]))
    else $error("select fields not stored apart");

  presc_clear_a: assert property (@(posedge CLK) disable iff (RESET)
    ctrl_q.sync_rst |=> div_q == '0)
    else $error("prescaler reset did not clear divider");

  hold_keep_a: assert property (@(posedge CLK) disable iff (RESET)
    ctrl_q.hold && ctrl_q.sync_rst && !wr_ctrl
    |=> ctrl_q.sync_rst)
    else $error("held reset bit dropped");

  self_clear_a: assert property (@(posedge CLK) disable iff (RESET)
    !ctrl_q.hold && ctrl_q.sync_rst && !wr_ctrl |=> !ctrl_q.sync_rst)
    else $error("reset bit did not self clear");

  apb_answer_a: assert property (@(posedge CLK) disable iff (RESET)
    access && !pready_q |=> pready_q ##1 !pready_q)
    else $error("apb answer not one cycle");

  // write lands at the ready edge, divider clears one edge later
  sync_reset_a: assert property (@(posedge CLK) disable iff (RESET)
    wr_ctrl && PWDATA[`BIT_SYNC_RST]
    |=> ctrl_q.sync_rst ##1 (div_q == '0))
    else $error("prescaler reset write had no effect");

  hold_release_a: assert property (@(posedge CLK) disable iff (RESET)
    wr_ctrl && !PWDATA[`BIT_HOLD]
    |=> ##1 (!ctrl_q.sync_rst && !ctrl_q.async_rst))
    else $error("reset bits not cleared after hold release");

  // copy is registered so the separate timer sees a clean level
  async_level_a: assert property (@(posedge CLK) disable iff (RESET)
    !$past(RESET) |-> ASYNC_PRESCALER_RESET == $past(ctrl_q.async_rst))
    else $error("async reset output lags its bit");

  slverr_map_a: assert property (@(posedge CLK) disable iff (RESET)
    pready_q |-> pslverr_q == (rd_id == tmr_presc_pkg::REG_NONE))
    else $error("error response does not match address map");

  ext_tick_c: cover property (@(posedge CLK) disable iff (RESET)
    sel_q[0] == 3'h7 && tick_q[0]);
  hold_release_c: cover property (@(posedge CLK) disable iff (RESET)
    ctrl_q.hold ##1 !ctrl_q.hold && ctrl_q.sync_rst);
  div1024_c: cover property (@(posedge CLK) disable iff (RESET)
    sel_q[0] == 3'h5 && tick_q[0]);
  ext_fall_c: cover property (@(posedge CLK) disable iff (RESET)
    sel_q[1] == 3'h6 && tick_q[1]);
  held_fall_c: cover property (@(posedge CLK) disable iff (RESET)
    ctrl_q.sync_rst && sel_q[1] == 3'h6 && tick_q[1]);

endmodule // shared_timer_prescaler

// ===== tb/ext_clk_src.sv
`timescale 1ns/100ps
// far-side count clock: toggles every half cycles while run is high
module ext_clk_src (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // control
  input wire logic run,
  input wire logic [3:0] half,
  // count pin
  output logic pin_q
);
  logic [3:0] cnt_q;

  // pin only moves while running, so it is stable around select changes
  always_ff @(posedge clk) begin
    if (reset) begin
      pin_q <= 1'b0;
      cnt_q <= 4'h1;
    end else if (!run) begin
      cnt_q <= 4'h1;
    end else if (cnt_q == half) begin
      pin_q <= ~pin_q;
      cnt_q <= 4'h1;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule // ext_clk_src

// ===== tb/shared_timer_prescaler_test.sv
`timescale 1ns/100ps
`include "tmr_presc_cfg.svh"
module shared_timer_prescaler_test;
  logic CLK = 1'b0;
  logic RESET = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0;
  logic PREADY, PSLVERR, ASYNC_PRESCALER_RESET, pin_q;
  logic [31:0] PRDATA;
  logic [1:0] TIMER_TICK;
  logic run = 1'b0;
  logic [3:0] half = 4'h3;
  logic [33:0] expq[$];
  logic [33:0] e;
  int fail_count = 0, cmp_count = 0, cyc = 0, n0 = 0, n1 = 0;
  int seed = 32'h3FD1;
  int sh[6] = '{0, 0, 3, 6, 8, 10};

  always #50 CLK = ~CLK;

  shared_timer_prescaler shared_timer_prescaler_i (.CLK(CLK), .RESET(RESET),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
    .EXT_COUNT_PIN({2{pin_q}}), .TIMER_TICK(TIMER_TICK),
    .ASYNC_PRESCALER_RESET(ASYNC_PRESCALER_RESET));
  ext_clk_src ext_clk_src_i (.clk(CLK), .reset(RESET), .run(run),
    .half(half), .pin_q(pin_q));

  task summarize();
    if (fail_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string w);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask

  task chk_ticks(input int e0, input int e1);
    chk(n0, e0, "tick count timer0");
    chk(n1, e1, "tick count timer1");
  endtask

  // expectation layout: {check data, error, data}
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
           input logic [33:0] x);
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    expq.push_back(x);
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1) @(posedge CLK);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d, input logic err);
    apb(1'b1, a, d, {1'b0, err, 32'h0});
  endtask

  task rd(input logic [11:0] a, input logic [31:0] d, input logic err);
    apb(1'b0, a, 32'h0, {1'b1, err, d});
  endtask

  // settle a few cycles, then count ticks over c cycles
  task win(input int c);
    repeat (4) @(posedge CLK);
    n0 = 0;
    n1 = 0;
    repeat (c) @(posedge CLK);
  endtask

  // negedge sampling avoids racing the clearing done after posedge
  always @(negedge CLK) begin
    if (TIMER_TICK[0] === 1'b1) n0++;
    if (TIMER_TICK[1] === 1'b1) n1++;
    if (!RESET && ^TIMER_TICK === 1'bx) begin
      fail_count++;
      $display("MISMATCH t=%0t tick output unknown", $time);
    end
  end

  always @(posedge CLK) begin
    if (PSEL === 1'b1 && PENABLE === 1'b1 && PREADY === 1'b1) begin
      e = expq.pop_front();
      chk({31'h0, PSLVERR}, {31'h0, e[32]}, "error response");
      if (e[33]) chk(PRDATA, e[31:0], "read data");
    end
  end

  always @(posedge CLK) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      summarize();
    end
  end

  initial begin
    repeat (8) @(posedge CLK);
    RESET <= 1'b0;
    rd(`OFS_SYNC_CTRL, 32'h0, 1'b0);
    rd(`OFS_CLK_SEL, 32'h0, 1'b0);
    rd(12'h00C, 32'h0, 1'b1);
    wr(12'h010, 32'hFFFF_FFFF, 1'b1);
    win(64);
    chk_ticks(0, 0);
    wr(`OFS_CLK_SEL, 32'h11, 1'b0);
    win(16);
    chk_ticks(16, 16);
    for (int s = 2; s < 6; s++) begin
      wr(`OFS_CLK_SEL, 32'h20 | s, 1'b0);
      wr(`OFS_SYNC_CTRL, 32'h1, 1'b0);
      win(2048);
      chk_ticks(2048 >> sh[s], 256);
    end
    wr(`OFS_SYNC_CTRL, 32'h83, 1'b0);
    rd(`OFS_SYNC_CTRL, 32'h83, 1'b0);
    rd(`OFS_DIV_COUNT, 32'h0, 1'b0);
    chk({31'h0, ASYNC_PRESCALER_RESET}, 32'h1, "async reset level");
    win(64);
    chk_ticks(0, 0);
    wr(`OFS_SYNC_CTRL, 32'h3, 1'b0);
    rd(`OFS_SYNC_CTRL, 32'h0, 1'b0);
    chk({31'h0, ASYNC_PRESCALER_RESET}, 32'h0, "async reset level");
    win(1024);
    chk_ticks(1, 128);
    wr(`OFS_SYNC_CTRL, 32'h1, 1'b0);
    rd(`OFS_SYNC_CTRL, 32'h0, 1'b0);
    wr(`OFS_CLK_SEL, 32'hFFFF_FF88, 1'b0);
    rd(`OFS_CLK_SEL, 32'h0, 1'b0);
    for (int k = 0; k < 2; k++) begin
      half <= 4'(2 + ($random(seed) & 3));
      if (k == 1) wr(`OFS_SYNC_CTRL, 32'h81, 1'b0);
      wr(`OFS_CLK_SEL, 32'h67, 1'b0);
      repeat (4) @(posedge CLK);
      n0 = 0;
      n1 = 0;
      run <= 1'b1;
      repeat (8 * half) @(posedge CLK);
      run <= 1'b0;
      repeat (6) @(posedge CLK);
      chk_ticks(4, 4);
    end
    summarize();
  end
endmodule // shared_timer_prescaler_test
